// ---- shared/rsdf_pkg.sv ----
// Constants shared by the stop, summer-time and status flag block
package rsdf_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_SECONDS = 8'h00;
    localparam logic [7:0] ADDR_MINUTES = 8'h02;
    localparam logic [7:0] ADDR_HOURS   = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h0A;
    localparam logic [7:0] ADDR_STATUS  = 8'h0B;
    // Control register fields
    localparam int         BIT_HALT     = 7;
    localparam int         BIT_SUMMER   = 4;
    localparam logic [7:0] CONTROL_RST  = 8'h00;
    // Status register fields
    localparam int         BIT_ALARM    = 7;
    localparam int         BIT_OSCFAIL  = 6;
    localparam int         BIT_PWRLOSS  = 5;
    localparam int         BIT_CLRPIN   = 4;
    localparam int         BATT_W       = 3;
    // Prescaler shape: stage 0 is clocked by the crystal
    localparam int         PRESC_W      = 15;
    localparam int         STAGE_1K     = 4;
    localparam int         STAGE_32     = 9;
    localparam int         STAGE_LAST   = 14;
    localparam int         XTAL_HZ      = 32768;
    // Extra crystal edges the upper stages stay cleared after halt release
    localparam int         RESTART_GATE = 260;
    // Oscillator watchdog
    localparam int         SYS_PERIOD_NS  = 4;
    localparam int         OSC_TIMEOUT_NS = 100000;
    localparam int         OSC_TIMEOUT_CYC = OSC_TIMEOUT_NS / SYS_PERIOD_NS;
    // Time of day limits and summer-time hours
    localparam logic [5:0] MAX_SEC      = 6'h3B;
    localparam logic [5:0] MAX_MIN      = 6'h3B;
    localparam logic [4:0] MAX_HOUR     = 5'h17;
    localparam logic [4:0] SWITCH_HOUR  = 5'h01;
    localparam logic [4:0] SPRING_HOUR  = 5'h03;
endpackage : rsdf_pkg

// ---- shared/rsdf_tick_if.sv ----
// Carrier between the prescaler and the status/time logic
interface rsdf_tick_if;
    logic halt;        // Upper stages held cleared
    logic sec_tick;    // One-cycle pulse per second
    logic xtal_level;  // Registered crystal level
    logic f1k024;      // 1.024 kHz stage
    logic f32;         // 32 Hz stage
    logic f1;          // 1 Hz stage
    logic osc_running; // Crystal edges seen recently
    modport presc (input halt, output sec_tick, xtal_level, f1k024, f32, f1, osc_running);
    modport core  (output halt, input sec_tick, xtal_level, f1k024, f32, f1, osc_running);
endinterface : rsdf_tick_if

// ---- hw/rsdf_prescaler.sv ----
// Crystal prescaler with halt reset, restart gate and oscillator watchdog
module rsdf_prescaler #(
    parameter int OSC_TIMEOUT_CYC = rsdf_pkg::OSC_TIMEOUT_CYC,
    parameter int GATE_EDGES      = rsdf_pkg::RESTART_GATE
) (
    // Clock and reset
    input  wire logic  clk_sys_in,
    input  wire logic  rst_b_in,
    // Crystal level, synchronous to clk_sys_in
    input  wire logic  xtal_in,
    // Toward the core
    rsdf_tick_if.presc tick_if
);
    localparam int OW = $clog2(OSC_TIMEOUT_CYC + 1);
    localparam int GW = $clog2(GATE_EDGES + 1);
    localparam int UW = rsdf_pkg::PRESC_W - 2;

    logic          xtal_q;   // Previous crystal level
    logic          xtal_rise; // Stage 0 clocking event
    logic [1:0]    low2;     // Stages 0 and 1, never cleared by halt
    logic [UW-1:0] upper;    // Stages 2 to 14
    logic [GW-1:0] gate;     // Restart gate countdown
    logic          last_q;   // Delayed last stage for edge detect
    logic [OW-1:0] wdog;     // Cycles since last crystal edge

    assign xtal_rise = xtal_in & ~xtal_q;

    // Crystal edge detect
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            xtal_q <= 1'b0;
        end else begin
            xtal_q <= xtal_in;
        end
    end

    // Lowest two stages run from the crystal regardless of halt
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            low2 <= 2'h0;
        end else if (xtal_rise) begin
            low2 <= low2 + 2'h1;
        end
    end

    // Gate reloads while halted; it lines the first tick up with the restart window
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            gate <= GW'(GATE_EDGES);
        end else if (tick_if.halt) begin
            gate <= GW'(GATE_EDGES);
        end else if (xtal_rise && gate != '0) begin
            gate <= gate - GW'(1);
        end
    end

    // Upper stages count carries out of stage 1
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            upper <= '0;
        end else if (tick_if.halt) begin
            upper <= '0;
        end else if (xtal_rise && low2 == 2'h3 && gate == '0) begin
            upper <= upper + UW'(1);
        end
    end

    // Last stage edge detect
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            last_q <= 1'b0;
        end else begin
            last_q <= upper[rsdf_pkg::STAGE_LAST-2];
        end
    end

    // Watchdog starts expired so power-up counts as a stopped oscillator
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            wdog <= OW'(OSC_TIMEOUT_CYC);
        end else if (xtal_rise) begin
            wdog <= '0;
        end else if (wdog != OW'(OSC_TIMEOUT_CYC)) begin
            wdog <= wdog + OW'(1);
        end
    end

    assign tick_if.sec_tick    = upper[rsdf_pkg::STAGE_LAST-2] & ~last_q;
    assign tick_if.xtal_level  = xtal_q;
    assign tick_if.f1k024      = upper[rsdf_pkg::STAGE_1K-2];
    assign tick_if.f32         = upper[rsdf_pkg::STAGE_32-2];
    assign tick_if.f1          = upper[rsdf_pkg::STAGE_LAST-2];
    assign tick_if.osc_running = (wdog != OW'(OSC_TIMEOUT_CYC));

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    halt_clears_upper_a: assert property (tick_if.halt |=> upper == '0 && !tick_if.sec_tick)
        else $error("upper stages ran while halted");
    gate_reload_a: assert property (tick_if.halt |=> gate == GW'(GATE_EDGES))
        else $error("restart gate not reloaded during halt");
    low_stages_run_a: assert property (xtal_rise |=> low2 == $past(low2) + 2'h1)
        else $error("low stages did not follow crystal");
endmodule : rsdf_prescaler

// ---- hw/rsdf_status_top.sv ----
// Time counters with halt, summer-time switching and the status flag register
// Functional notes
// - Stage zero clocked by 32.768 kHz crystal.
// - Halt clears upper stages, freezes time.
// - Seconds advance on last stage rising.
// - First tick 0.507813 to 0.507935 s later.
// - Spring Sunday jumps 1:59:59 to 3:00:00.
// - Autumn Sunday falls back once to 1:00:00.
// - Battery code refreshed once per second.
// - Status layout: flags 7..4, code 2..0.
// - Battery code ignores host writes.
// - Alarm flag set on match, cleared.
// - Oscillator flag set power-up, stop, halt.
// - Power-loss flag set after total supply loss.
// - Clear-pin flag set on pin assertion.
// - Oscillator flag stays while oscillator stopped.
// - Battery code 000 low to 111 high.
// - Halt stops 1.024 kHz, 32 Hz, 1 Hz.
module rsdf_status_top #(
    parameter int OSC_TIMEOUT_CYC = rsdf_pkg::OSC_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic                      clk_sys_in,
    input  wire logic                      rst_b_in,
    // Crystal and derived frequencies
    input  wire logic                      xtal_in,
    output logic                           clk_32k768_out,
    output logic                           clk_1k024_out,
    output logic                           clk_32hz_out,
    output logic                           clk_1hz_out,
    // Register port
    input  wire logic                      reg_wr_en_in,
    input  wire logic [7:0]                reg_addr_in,
    input  wire logic [7:0]                reg_wdata_in,
    output logic      [7:0]                reg_rdata_out,
    // Event and level sources
    input  wire logic                      external_clear_input_in,
    input  wire logic                      alarm_match_in,
    input  wire logic [rsdf_pkg::BATT_W-1:0] battery_level_code_in,
    input  wire logic                      power_loss_strap_in,
    input  wire logic                      spring_sunday_in,
    input  wire logic                      autumn_sunday_in
);
    rsdf_tick_if tick_if ();

    logic [7:0] control;                 // Control register
    logic       halt_time_circuits;      // Stop bit
    logic       summer_time_enable;      // Summer-time mode
    logic [5:0] seconds;                 // Time of day, binary
    logic [5:0] minutes;
    logic [4:0] hours;
    logic       fall_done;               // Autumn hour already repeated today
    logic       alarm_match_flag;
    logic       oscillator_failure_flag;
    logic       power_loss_flag;
    logic       clear_pin_flag;
    logic [rsdf_pkg::BATT_W-1:0] battery_level_code;
    logic       strap_pending;           // First cycle after reset release
    logic       clr_q;                   // Clear pin previous level
    logic       clr_event;               // Clear pin assertion
    logic       end_of_hour;             // 59:59 reached on this tick
    logic       spring_jump;
    logic       fall_back;
    logic       wr_status;
    logic       wr_time;
    logic [7:0] next_rdata;

    // Write strobe for one register
    function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] off);
        wr_hit = en && (a == off);
    endfunction : wr_hit

    rsdf_prescaler #(
        .OSC_TIMEOUT_CYC (OSC_TIMEOUT_CYC),
        .GATE_EDGES      (rsdf_pkg::RESTART_GATE)
    ) u_presc (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .xtal_in    (xtal_in),
        .tick_if    (tick_if)
    );

    assign halt_time_circuits = control[rsdf_pkg::BIT_HALT];
    assign summer_time_enable = control[rsdf_pkg::BIT_SUMMER];
    assign tick_if.halt       = halt_time_circuits;
    assign wr_status          = wr_hit(reg_wr_en_in, reg_addr_in, rsdf_pkg::ADDR_STATUS);
    assign wr_time            = wr_hit(reg_wr_en_in, reg_addr_in, rsdf_pkg::ADDR_SECONDS)
                              | wr_hit(reg_wr_en_in, reg_addr_in, rsdf_pkg::ADDR_MINUTES)
                              | wr_hit(reg_wr_en_in, reg_addr_in, rsdf_pkg::ADDR_HOURS);
    assign clr_event          = external_clear_input_in & ~clr_q;
    assign end_of_hour        = tick_if.sec_tick && seconds == rsdf_pkg::MAX_SEC
                              && minutes == rsdf_pkg::MAX_MIN;
    assign spring_jump        = end_of_hour && summer_time_enable && spring_sunday_in
                              && hours == rsdf_pkg::SWITCH_HOUR;
    assign fall_back          = end_of_hour && summer_time_enable && autumn_sunday_in
                              && hours == rsdf_pkg::SWITCH_HOUR && !fall_done;

    // Control register, other bits kept for read-back only
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            control <= rsdf_pkg::CONTROL_RST;
        end else if (wr_hit(reg_wr_en_in, reg_addr_in, rsdf_pkg::ADDR_CONTROL)) begin
            control <= reg_wdata_in;
        end
    end

    // Time counters; a host write wins over a same-cycle tick
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            seconds <= '0;
            minutes <= '0;
            hours   <= '0;
        end else if (wr_time) begin
            if (reg_addr_in == rsdf_pkg::ADDR_SECONDS) begin
                seconds <= reg_wdata_in[5:0];
            end else if (reg_addr_in == rsdf_pkg::ADDR_MINUTES) begin
                minutes <= reg_wdata_in[5:0];
            end else begin
                hours <= reg_wdata_in[4:0];
            end
        end else if (tick_if.sec_tick) begin
            if (seconds != rsdf_pkg::MAX_SEC) begin
                seconds <= seconds + 6'h01;
            end else begin
                seconds <= '0;
                if (minutes != rsdf_pkg::MAX_MIN) begin
                    minutes <= minutes + 6'h01;
                end else begin
                    minutes <= '0;
                    if (spring_jump) begin
                        hours <= rsdf_pkg::SPRING_HOUR;
                    end else if (fall_back) begin
                        hours <= rsdf_pkg::SWITCH_HOUR;
                    end else if (hours == rsdf_pkg::MAX_HOUR) begin
                        hours <= '0;
                    end else begin
                        hours <= hours + 5'h01;
                    end
                end
            end
        end
    end

    // Fall-back is armed again only once the autumn Sunday is over
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            fall_done <= 1'b0;
        end else if (!autumn_sunday_in) begin
            fall_done <= 1'b0;
        end else if (fall_back) begin
            fall_done <= 1'b1;
        end
    end

    // Clear pin edge detect; input is synchronous
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            clr_q <= 1'b0;
        end else begin
            clr_q <= external_clear_input_in;
        end
    end

    // Alarm flag; a match beats both the pin clear and a written zero
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            alarm_match_flag <= 1'b0;
        end else if (tick_if.sec_tick && alarm_match_in) begin
            alarm_match_flag <= 1'b1;
        end else if (clr_event || (wr_status && !reg_wdata_in[rsdf_pkg::BIT_ALARM])) begin
            alarm_match_flag <= 1'b0;
        end
    end

    // Oscillator flag; a clear cannot land while the crystal is stopped
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            oscillator_failure_flag <= 1'b1;
        end else if (!tick_if.osc_running
                     || (wr_hit(reg_wr_en_in, reg_addr_in, rsdf_pkg::ADDR_CONTROL)
                         && reg_wdata_in[rsdf_pkg::BIT_HALT])) begin
            oscillator_failure_flag <= 1'b1;
        end else if (wr_status && !reg_wdata_in[rsdf_pkg::BIT_OSCFAIL]) begin
            oscillator_failure_flag <= 1'b0;
        end
    end

    // Power-loss strap caught on the first cycle after reset release
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            strap_pending   <= 1'b1;
            power_loss_flag <= 1'b0;
        end else begin
            strap_pending <= 1'b0;
            if (strap_pending && power_loss_strap_in) begin
                power_loss_flag <= 1'b1;
            end else if (wr_status && !reg_wdata_in[rsdf_pkg::BIT_PWRLOSS]) begin
                power_loss_flag <= 1'b0;
            end
        end
    end

    // Clear-pin flag stays until the host writes zero
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            clear_pin_flag <= 1'b0;
        end else if (clr_event) begin
            clear_pin_flag <= 1'b1;
        end else if (wr_status && !reg_wdata_in[rsdf_pkg::BIT_CLRPIN]) begin
            clear_pin_flag <= 1'b0;
        end
    end

    // Battery code sampled once a second; writes never reach it
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            battery_level_code <= '0;
        end else if (tick_if.sec_tick) begin
            battery_level_code <= battery_level_code_in;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        if (reg_addr_in == rsdf_pkg::ADDR_STATUS) begin
            next_rdata = {alarm_match_flag, oscillator_failure_flag, power_loss_flag,
                          clear_pin_flag, 1'b0, battery_level_code};
        end else if (reg_addr_in == rsdf_pkg::ADDR_CONTROL) begin
            next_rdata = control;
        end else if (reg_addr_in == rsdf_pkg::ADDR_SECONDS) begin
            next_rdata = {2'h0, seconds};
        end else if (reg_addr_in == rsdf_pkg::ADDR_MINUTES) begin
            next_rdata = {2'h0, minutes};
        end else if (reg_addr_in == rsdf_pkg::ADDR_HOURS) begin
            next_rdata = {3'h0, hours};
        end else begin
            next_rdata = 8'h00;
        end
    end

    // Registered read data and frequency outputs
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            reg_rdata_out  <= 8'h00;
            clk_32k768_out <= 1'b0;
            clk_1k024_out  <= 1'b0;
            clk_32hz_out   <= 1'b0;
            clk_1hz_out    <= 1'b0;
        end else begin
            reg_rdata_out  <= next_rdata;
            clk_32k768_out <= tick_if.xtal_level;
            clk_1k024_out  <= tick_if.f1k024;
            clk_32hz_out   <= tick_if.f32;
            clk_1hz_out    <= tick_if.f1;
        end
    end

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    sec_advance_a: assert property (tick_if.sec_tick && !wr_time && seconds != rsdf_pkg::MAX_SEC
        |=> seconds == $past(seconds) + 6'h01)
        else $error("seconds did not advance on tick");
    halt_freeze_a: assert property (halt_time_circuits && !wr_time ##1 !wr_time |=> $stable(seconds))
        else $error("time moved while halted");
    spring_jump_a: assert property (spring_jump && !wr_time |=> hours == rsdf_pkg::SPRING_HOUR
        && minutes == '0 && seconds == '0)
        else $error("spring jump missed");
    fall_once_a: assert property (end_of_hour && !wr_time && summer_time_enable && autumn_sunday_in
        && hours == rsdf_pkg::SWITCH_HOUR && fall_done |=> hours == rsdf_pkg::SPRING_HOUR - 5'h01)
        else $error("hour repeated twice");
    batt_refresh_a: assert property (tick_if.sec_tick |=> battery_level_code == $past(battery_level_code_in))
        else $error("battery code not refreshed");
    batt_readonly_a: assert property (wr_status && !tick_if.sec_tick |=> $stable(battery_level_code))
        else $error("battery code changed by write");
    status_layout_a: assert property (reg_addr_in == rsdf_pkg::ADDR_STATUS
        |=> reg_rdata_out == {$past(alarm_match_flag), $past(oscillator_failure_flag), $past(power_loss_flag),
                              $past(clear_pin_flag), 1'b0, $past(battery_level_code)})
        else $error("status read layout wrong");
    alarm_set_a: assert property (tick_if.sec_tick && alarm_match_in |=> alarm_match_flag)
        else $error("alarm flag not set");
    osc_hold_a: assert property (!tick_if.osc_running |=> oscillator_failure_flag)
        else $error("oscillator flag cleared while stopped");
    clrpin_set_a: assert property (clr_event |=> clear_pin_flag && !alarm_match_flag
        || $past(tick_if.sec_tick && alarm_match_in))
        else $error("clear pin event mishandled");
    write_one_a: assert property (wr_status && reg_wdata_in[rsdf_pkg::BIT_CLRPIN] && clear_pin_flag
        |=> clear_pin_flag)
        else $error("written one cleared a flag");
endmodule : rsdf_status_top

// ---- dv/rsdf_xtal_model.sv ----
// Crystal oscillator model that the bench can stop to provoke a failure
module rsdf_xtal_model (
    // Clock and run control
    input  wire logic clk_sys_in,
    input  wire logic run_in,
    // Crystal level toward the block
    output logic      xtal_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Fastest legal crystal keeps whole seconds inside the run; a stopped one parks low
    // Single driver: the bench holds run low through reset, so the first edge parks it low
    always @(posedge clk_sys_in) begin
        xtal_out <= #1 run_in ? ~xtal_out : 1'b0;
    end
endmodule : rsdf_xtal_model

// ---- dv/rsdf_status_top_tb.sv ----
// Self-checking bench for the halt, summer-time and status flag block
module rsdf_status_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LO_CYC = 16640 * 2;      // Earliest first tick, two cycles per crystal edge
    localparam int HI_CYC = 16644 * 2 + 16; // Latest, plus sync and read slack
    localparam int LIMIT  = 90000;          // Two restarts need about 67000 cycles
    // Design stimulus and observation
    logic       clk_sys_in, rst_b_in, xtal_in, xtal_run;
    logic       c_32k, c_1k, c_32, c_1;
    logic       reg_wr_en_in, ext_clr, alarm_in, strap, spring, autumn;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic [2:0] batt;
    int         mismatches, cmp_count, cycles;
    // Crystal partner
    rsdf_xtal_model xtal_u (.clk_sys_in(clk_sys_in), .run_in(xtal_run), .xtal_out(xtal_in));
    // Short watchdog so a stopped crystal is noticed quickly
    rsdf_status_top #(.OSC_TIMEOUT_CYC(64)) dut_u (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .xtal_in(xtal_in),
        .clk_32k768_out(c_32k), .clk_1k024_out(c_1k), .clk_32hz_out(c_32), .clk_1hz_out(c_1),
        .reg_wr_en_in(reg_wr_en_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .external_clear_input_in(ext_clr), .alarm_match_in(alarm_in),
        .battery_level_code_in(batt), .power_loss_strap_in(strap),
        .spring_sunday_in(spring), .autumn_sunday_in(autumn));
    // 250 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    // Compare and count
    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Wait n cycles, landing just after an edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : cyc
    // One-cycle write strobe, then an idle edge so a following write never re-raises it in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr_en_in = 1'b1;
        reg_addr_in  = a;
        reg_wdata_in = d;
        cyc(1);
        reg_wr_en_in = 1'b0;
        cyc(1);
    endtask : wr
    // Read answers one edge after the address
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        reg_addr_in = a;
        cyc(1);
        chk(what, reg_rdata_out, exp);
    endtask : rd_chk
    // Clear pin pulse; rising edge is the event
    task automatic pulse_clr;
        ext_clr = 1'b1;
        cyc(2);
        ext_clr = 1'b0;
        cyc(4);
    endtask : pulse_clr
    // Halt, load 01:59:59 and clear flags
    task automatic load_edge_time;
        wr(rsdf_pkg::ADDR_CONTROL, 8'h90);
        wr(rsdf_pkg::ADDR_SECONDS, 8'h3B);
        wr(rsdf_pkg::ADDR_MINUTES, 8'h3B);
        wr(rsdf_pkg::ADDR_HOURS, 8'h01);
        wr(rsdf_pkg::ADDR_STATUS, 8'h00);
    endtask : load_edge_time
    // Release halt and time the first second increment
    task automatic release_and_time;
        int n;
        wr(rsdf_pkg::ADDR_CONTROL, 8'h10);
        reg_addr_in = rsdf_pkg::ADDR_SECONDS;
        cyc(1);
        n = 1;
        while (reg_rdata_out === 8'h3B && n < HI_CYC + 50) begin
            cyc(1);
            n++;
        end
        chk("first tick in window", {7'h00, n >= LO_CYC && n <= HI_CYC}, 8'h01);
    endtask : release_and_time
    // Reset values, layout and unmapped read
    task automatic t_reset;
        rd_chk("status after reset", rsdf_pkg::ADDR_STATUS, 8'h60);
        rd_chk("control after reset", rsdf_pkg::ADDR_CONTROL, 8'h00);
        rd_chk("unmapped read", 8'h3F, 8'h00);
    endtask : t_reset
    // Flag clearing, stopped crystal and clear pin
    task automatic t_flags;
        wr(rsdf_pkg::ADDR_STATUS, 8'h00);
        rd_chk("clear while stopped", rsdf_pkg::ADDR_STATUS, 8'h40);
        xtal_run = 1'b1;
        cyc(8);
        wr(rsdf_pkg::ADDR_STATUS, 8'hFF);
        rd_chk("ones keep flags", rsdf_pkg::ADDR_STATUS, 8'h40);
        wr(rsdf_pkg::ADDR_STATUS, 8'h00);
        rd_chk("clear oscillator flag", rsdf_pkg::ADDR_STATUS, 8'h00);
        pulse_clr();
        rd_chk("clear pin flag", rsdf_pkg::ADDR_STATUS, 8'h10);
        wr(rsdf_pkg::ADDR_STATUS, 8'hEF);
        rd_chk("clear pin flag cleared", rsdf_pkg::ADDR_STATUS, 8'h00);
        xtal_run = 1'b0;
        cyc(80);
        rd_chk("crystal stop sets flag", rsdf_pkg::ADDR_STATUS, 8'h40);
        xtal_run = 1'b1;
        cyc(8);
    endtask : t_flags
    // Halt effects, restart timing, spring jump, alarm and battery
    task automatic t_spring;
        logic a;
        load_edge_time();
        wr(rsdf_pkg::ADDR_CONTROL, 8'h90);
        rd_chk("halt sets oscillator flag", rsdf_pkg::ADDR_STATUS, 8'h40);
        wr(rsdf_pkg::ADDR_STATUS, 8'h00);
        cyc(40);
        for (int i = 0; i < 8; i++) begin
            a = c_32k;
            cyc(1);
            chk("divided outputs halted", {5'h00, c_1k, c_32, c_1}, 8'h00);
            chk("crystal output runs", {7'h00, a ^ c_32k}, 8'h01);
        end
        batt     = 3'h5;
        alarm_in = 1'b1;
        spring   = 1'b1;
        release_and_time();
        alarm_in = 1'b0;
        // Running again: 1.024 kHz stage flips every 32 cycles, 1 Hz stage high after the tick
        a = c_1k;
        cyc(32);
        chk("divided outputs run", {6'h00, a ^ c_1k, c_1}, 8'h03);
        rd_chk("spring hours", rsdf_pkg::ADDR_HOURS, 8'h03);
        rd_chk("spring minutes", rsdf_pkg::ADDR_MINUTES, 8'h00);
        rd_chk("spring seconds", rsdf_pkg::ADDR_SECONDS, 8'h00);
        rd_chk("alarm and battery", rsdf_pkg::ADDR_STATUS, 8'h85);
        pulse_clr();
        rd_chk("pin clears alarm", rsdf_pkg::ADDR_STATUS, 8'h15);
    endtask : t_spring
    // Autumn fall-back and battery refresh
    task automatic t_autumn;
        spring = 1'b0;
        autumn = 1'b1;
        batt   = 3'h2;
        load_edge_time();
        rd_chk("battery frozen while halted", rsdf_pkg::ADDR_STATUS, 8'h05);
        release_and_time();
        rd_chk("autumn hours", rsdf_pkg::ADDR_HOURS, 8'h01);
        rd_chk("autumn minutes", rsdf_pkg::ADDR_MINUTES, 8'h00);
        rd_chk("autumn seconds", rsdf_pkg::ADDR_SECONDS, 8'h00);
        rd_chk("battery refreshed", rsdf_pkg::ADDR_STATUS, 8'h02);
    endtask : t_autumn
    // Counts, verdict and end of run
    task automatic summarize;
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    // Hang guard
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            summarize();
        end
    end
    // Main sequence
    initial begin
        {rst_b_in, xtal_run, reg_wr_en_in, ext_clr, alarm_in, spring, autumn} = '0;
        {reg_addr_in, reg_wdata_in, batt} = '0;
        strap = 1'b1;
        {mismatches, cmp_count, cycles} = '0;
        cyc(12);
        rst_b_in = 1'b1;
        cyc(2);
        t_reset();
        t_flags();
        t_spring();
        t_autumn();
        summarize();
    end
endmodule : rsdf_status_top_tb
